/* mior_defines.svh */
/*
  Constants of the multi-line read path: opcodes, phase lengths in serial
  clocks, field positions and reset values. Assumes inclusion by bare name.
*/
`ifndef MIOR_DEFINES_SVH
`define MIOR_DEFINES_SVH

// Opcodes
`define MIOR_OP_QOUT 8'h6b
`define MIOR_OP_DIO 8'hbb
`define MIOR_OP_QIO 8'heb
`define MIOR_OP_QWORD 8'he7
`define MIOR_OP_ID 8'h90
`define MIOR_OP_WRAP 8'h77
`define MIOR_OP_CONT_RST 8'hff

// Phase lengths in serial clocks
`define MIOR_CMD_CLKS 6'h08
`define MIOR_ADDR_CLKS_X1 6'h18
`define MIOR_ADDR_CLKS_X2 6'h0c
`define MIOR_ADDR_CLKS_X4 6'h06
`define MIOR_WRAP_CLKS 6'h08
`define MIOR_MODE_CLKS_X2 6'h04
`define MIOR_MODE_CLKS_X4 6'h02
`define MIOR_DUMMY_QOUT 6'h08
`define MIOR_DUMMY_QIO 6'h04
`define MIOR_DUMMY_QWORD 6'h02

// Mode byte and wrap byte fields
`define MIOR_CONT_LO 4
`define MIOR_CONT_HI 5
`define MIOR_CONT_KEEP 2'h2
`define MIOR_WRAP_DIS_POS 4
`define MIOR_WRAP_LEN_LO 5
`define MIOR_WRAP_LEN_HI 6

// Reset values
`define MIOR_WRAP_DIS_RST 1'h1
`define MIOR_WRAP_LEN_RST 2'h0
`define MIOR_STATUS_RST 5'h04

`endif

/* mior_pkg.sv */
/*
  Types of the multi-line read path: transfer phases, read kinds and lane
  widths. Assumes nothing of its surroundings.
*/
package mior_pkg;

  typedef enum logic [2:0] {
    PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_IGNORE
  } mior_phase_e;

  typedef enum logic [2:0] {
    RK_NONE, RK_QOUT, RK_DIO, RK_QIO, RK_QWORD, RK_ID, RK_WRAP
  } mior_kind_e;

  typedef enum logic [1:0] {
    LN_X1, LN_X2, LN_X4
  } mior_lanes_e;

endpackage

/* mior_sync.sv */
/*
  Three-stage synchroniser for quasi-static levels. A bit of the output
  changes only once the second and third stages agree. Assumes a
  synchronous active-low reset in the destination domain.
*/
module mior_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Destination clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Level in, settled level out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end else begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit, accept only an agreed value
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        o_q[b] <= RST[b];
      end else if (s2_q[b] == s3_q[b]) begin
        o_q[b] <= s3_q[b];
      end
    end
  end

endmodule

/* mior_top.sv */
/*
  Read-command front end of a serial flash: opcode decode, address, mode
  and dummy phases, data shifting on one, two or four lines, continuous
  read mode, wrapped bursts and the identity read. Assumes a host that
  drives the serial clock and an active-low select, and a memory array
  whose read data follows the address within one serial clock period.
*/
`include "mior_defines.svh"

module mior_top
  import mior_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h3c  // Arbitrary value
) (
  // System clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // Serial link
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic [3:0] I_IO,
  output logic [3:0] O_IO,
  output logic [3:0] O_IO_OE,
  // Memory array read port, link clock
  output logic [23:0] O_MEM_ADDR,
  input wire logic [7:0] I_MEM_DATA,
  // Configuration
  input wire logic I_QUAD_LINES_ENABLE,
  // Status, system clock
  output logic O_SELECTED,
  output logic O_CONT_MODE,
  output logic O_WRAP_DISABLE_BIT,
  output logic [1:0] O_WRAP_LENGTH_FIELD
);

  // Reset handed to the link side
  logic link_rst_q;
  // Frame state, link clock rising edge
  mior_phase_e ph_q;
  mior_kind_e kind_q;
  logic [5:0] cnt_q;
  logic [31:0] sh_q;
  logic [23:0] addr_q;
  logic id_swap_q;
  // Settings that outlive a frame
  logic cont_q;
  mior_kind_e cont_kind_q;
  logic wrap_dis_q;
  logic [1:0] wrap_len_q;
  // Output side, link clock falling edge
  logic [3:0] out_q;
  logic [3:0] oe_q;
  logic [2:0] beat_q;
  logic id_odd_q;
  logic [23:0] maddr_q;
  // Decode
  mior_phase_e cur_ph;
  mior_kind_e cur_kind;
  mior_phase_e nph;
  mior_kind_e nkind;
  mior_lanes_e in_lanes;
  mior_lanes_e out_lanes;
  logic [5:0] len;
  logic last;
  logic [31:0] sh_d;
  logic qe;
  logic [7:0] byte_out;
  logic [7:0] shifted;
  logic [3:0] beat_bits;
  logic [3:0] beat_oe;
  logic beat_last;
  logic [5:0] wmask;
  logic [23:0] inc_addr;
  logic [23:0] next_addr;
  logic wrap_on;

  // Held in reset while system reset is low
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      link_rst_q <= 1'b1;
    end else begin
      link_rst_q <= 1'b0;
    end
  end

  // Quad enable level brought onto the link clock
  mior_sync #(.W(1), .RST(1'b0)) u_qe_sync (
    .i_clk(I_SCLK),
    .i_rst_n(~link_rst_q),
    .i_d(I_QUAD_LINES_ENABLE),
    .o_q(qe)
  );

  // Status levels brought onto the system clock
  mior_sync #(.W(5), .RST(`MIOR_STATUS_RST)) u_status_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_NRST),
    .i_d({~I_CS_N, cont_q, wrap_dis_q, wrap_len_q}),
    .o_q({O_SELECTED, O_CONT_MODE, O_WRAP_DISABLE_BIT, O_WRAP_LENGTH_FIELD})
  );

  // Continuous mode turns clock zero into the first address clock
  always_comb begin
    cur_ph = ph_q;
    cur_kind = kind_q;
    if (ph_q == PH_CMD && cnt_q == 6'h00 && cont_q) begin
      cur_ph = PH_ADDR;
      cur_kind = cont_kind_q;
    end
  end

  // Lines sampled per clock for the current phase
  always_comb begin
    in_lanes = LN_X1;
    if (cur_ph != PH_CMD) begin
      unique case (cur_kind)
        RK_DIO: in_lanes = LN_X2;
        RK_QIO, RK_QWORD, RK_WRAP: in_lanes = LN_X4;
        default: in_lanes = LN_X1;
      endcase
    end
  end

  // Shift-in, most significant group first
  always_comb begin
    unique case (in_lanes)
      LN_X2: sh_d = {sh_q[29:0], I_IO[1:0]};
      LN_X4: sh_d = {sh_q[27:0], I_IO};
      default: sh_d = {sh_q[30:0], I_IO[0]};
    endcase
  end

  // Phase length and successor
  always_comb begin
    len = `MIOR_CMD_CLKS;
    nph = PH_IGNORE;
    nkind = cur_kind;
    unique case (cur_ph)
      PH_CMD: begin
        nph = PH_ADDR;
        unique case (sh_d[7:0])
          `MIOR_OP_QOUT: nkind = RK_QOUT;
          `MIOR_OP_DIO: nkind = RK_DIO;
          `MIOR_OP_QIO: nkind = qe ? RK_QIO : RK_NONE;
          `MIOR_OP_QWORD: nkind = qe ? RK_QWORD : RK_NONE;
          `MIOR_OP_ID: nkind = RK_ID;
          `MIOR_OP_WRAP: nkind = RK_WRAP;
          default: nkind = RK_NONE;
        endcase
        if (nkind == RK_NONE) begin
          nph = PH_IGNORE;
        end
      end
      PH_ADDR: begin
        unique case (cur_kind)
          RK_DIO: begin
            len = `MIOR_ADDR_CLKS_X2;
            nph = PH_MODE;
          end
          RK_QIO, RK_QWORD: begin
            len = `MIOR_ADDR_CLKS_X4;
            nph = PH_MODE;
          end
          RK_WRAP: begin
            len = `MIOR_WRAP_CLKS;
            nph = PH_IGNORE;
          end
          RK_ID: begin
            len = `MIOR_ADDR_CLKS_X1;
            nph = PH_DATA;
          end
          default: begin
            len = `MIOR_ADDR_CLKS_X1;
            nph = PH_DUMMY;
          end
        endcase
      end
      PH_MODE: begin
        len = (cur_kind == RK_DIO) ? `MIOR_MODE_CLKS_X2 : `MIOR_MODE_CLKS_X4;
        nph = (cur_kind == RK_DIO) ? PH_DATA : PH_DUMMY;
      end
      PH_DUMMY: begin
        nph = PH_DATA;
        unique case (cur_kind)
          RK_QIO: len = `MIOR_DUMMY_QIO;
          RK_QWORD: len = `MIOR_DUMMY_QWORD;
          default: len = `MIOR_DUMMY_QOUT;
        endcase
      end
      default: begin
        len = `MIOR_CMD_CLKS;
        nph = cur_ph;
      end
    endcase
  end

  assign last = (cnt_q == len - 6'h01);

  // Frame sequencer; a high select clears it at once
  always_ff @(posedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      ph_q <= PH_CMD;
      kind_q <= RK_NONE;
      cnt_q <= 6'h00;
      sh_q <= 32'h0;
    end else if (cur_ph == PH_DATA || cur_ph == PH_IGNORE) begin
      ph_q <= cur_ph;
    end else begin
      sh_q <= sh_d;
      if (last) begin
        cnt_q <= 6'h00;
        ph_q <= nph;
        kind_q <= nkind;
      end else begin
        cnt_q <= cnt_q + 6'h01;
        ph_q <= cur_ph;
        kind_q <= cur_kind;
      end
    end
  end

  // Start address and identity order, caught at the end of the address
  always_ff @(posedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      addr_q <= 24'h0;
      id_swap_q <= 1'b0;
    end else if (cur_ph == PH_ADDR && last) begin
      addr_q <= sh_d[23:0];
      id_swap_q <= sh_d[0];
    end
  end

  // Settings survive select; system reset loads their reset values, and a mode byte without the keep pair clears cont_q
  always_ff @(posedge I_SCLK or posedge link_rst_q) begin
    if (link_rst_q) begin
      cont_q <= 1'b0;
      cont_kind_q <= RK_NONE;
      wrap_dis_q <= `MIOR_WRAP_DIS_RST;
      wrap_len_q <= `MIOR_WRAP_LEN_RST;
    end else if (!I_CS_N) begin
      if (cur_ph == PH_CMD && last && sh_d[7:0] == `MIOR_OP_CONT_RST) begin
        cont_q <= 1'b0;
      end
      if (cur_ph == PH_MODE && last) begin
        // Only the continuous-mode pair is looked at
        cont_q <= (sh_d[`MIOR_CONT_HI:`MIOR_CONT_LO] == `MIOR_CONT_KEEP);
        cont_kind_q <= cur_kind;
      end
      if (cur_ph == PH_ADDR && last && cur_kind == RK_WRAP) begin
        wrap_dis_q <= sh_d[`MIOR_WRAP_DIS_POS];
        wrap_len_q <= sh_d[`MIOR_WRAP_LEN_HI:`MIOR_WRAP_LEN_LO];
      end
    end
  end

  // Output line count per read kind
  always_comb begin
    unique case (kind_q)
      RK_DIO: out_lanes = LN_X2;
      RK_ID: out_lanes = LN_X1;
      default: out_lanes = LN_X4;
    endcase
  end

  // Byte on its way out: array data or an identity byte
  always_comb begin
    byte_out = I_MEM_DATA;
    if (kind_q == RK_ID) begin
      byte_out = (id_swap_q ^ id_odd_q) ? DEV_ID : MFR_ID;
    end
  end

  // Split the byte into beats, most significant bits first
  always_comb begin
    shifted = 8'h00;
    beat_bits = 4'h0;
    beat_oe = 4'h0;
    beat_last = 1'b0;
    unique case (out_lanes)
      LN_X4: begin
        beat_bits = beat_q[0] ? byte_out[3:0] : byte_out[7:4];
        beat_oe = 4'hf;
        beat_last = (beat_q == 3'h1);
      end
      LN_X2: begin
        shifted = byte_out << {beat_q[1:0], 1'b0};
        beat_bits = {2'h0, shifted[7:6]};
        beat_oe = 4'h3;
        beat_last = (beat_q == 3'h3);
      end
      default: begin
        shifted = byte_out << beat_q;
        beat_bits = {2'h0, shifted[7], 1'h0};
        beat_oe = 4'h2;
        beat_last = (beat_q == 3'h7);
      end
    endcase
  end

  // Lines turn around only while data is due
  always_ff @(negedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      out_q <= 4'h0;
      oe_q <= 4'h0;
      beat_q <= 3'h0;
      id_odd_q <= 1'b0;
    end else if (ph_q == PH_DATA) begin
      out_q <= beat_bits;
      oe_q <= beat_oe;
      if (beat_last) begin
        beat_q <= 3'h0;
        id_odd_q <= ~id_odd_q;
      end else begin
        beat_q <= beat_q + 3'h1;
      end
    end else begin
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end
  end

  // Wrap only for quad I/O and word reads
  assign wrap_on = !wrap_dis_q && (kind_q == RK_QIO || kind_q == RK_QWORD);

  // Section mask, always inside one 256-byte page
  always_comb begin
    unique case (wrap_len_q)
      2'h0: wmask = 6'h07;
      2'h1: wmask = 6'h0f;
      2'h2: wmask = 6'h1f;
      default: wmask = 6'h3f;
    endcase
  end

  assign inc_addr = maddr_q + 24'h1;

  // Low bits roll within the section, high bits hold
  always_comb begin
    next_addr = inc_addr;
    if (wrap_on) begin
      next_addr = (maddr_q & ~{18'h0, wmask}) | (inc_addr & {18'h0, wmask});
    end
  end

  // Array address moves as the last beat of a byte leaves
  always_ff @(negedge I_SCLK or posedge link_rst_q) begin
    if (link_rst_q) begin
      maddr_q <= 24'h0;
    end else if (ph_q != PH_DATA) begin
      maddr_q <= addr_q;
    end else if (beat_last && kind_q != RK_ID) begin
      maddr_q <= next_addr;
    end
  end

  // Pin and port drivers
  assign O_IO = out_q;
  assign O_IO_OE = oe_q;
  assign O_MEM_ADDR = maddr_q;

endmodule

/* mior_top_props.sv */
/* Checker for the read path ports.
   Assumes binding to every mior_top instance. */
module mior_top_props (
  // Clocks and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_SCLK,
  // Link and status
  input wire logic I_CS_N,
  input wire logic [3:0] O_IO_OE,
  input wire logic [23:0] O_MEM_ADDR,
  input wire logic O_SELECTED,
  input wire logic O_CONT_MODE,
  input wire logic O_WRAP_DISABLE_BIT,
  input wire logic [1:0] O_WRAP_LENGTH_FIELD
);
  timeunit 1ns;
  timeprecision 1ps;
  // Select held long enough to pass the status lag
  sequence s_held_low;
    !I_CS_N [*6];
  endsequence
  sequence s_held_high;
    I_CS_N [*8];
  endsequence
  a_idle_release: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_CS_N |-> O_IO_OE == 4'h0) else $error("lines driven while deselected");
  a_lane_codes: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_IO_OE inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("odd enable pattern");
  a_wrap_default: assert property (@(posedge I_CLK)
    !I_NRST [*2] |-> O_WRAP_DISABLE_BIT && O_WRAP_LENGTH_FIELD == 2'h0)
    else $error("wrap not off in reset");
  a_cont_default: assert property (@(posedge I_CLK)
    !I_NRST [*2] |-> !O_CONT_MODE && !O_SELECTED) else $error("mode set in reset");
  a_sel_follow: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    s_held_low |-> O_SELECTED) else $error("select not seen");
  a_sel_drop: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    s_held_high |-> !O_SELECTED) else $error("select stuck");
  a_keep_settings: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    s_held_high |-> $stable(O_CONT_MODE) && $stable(O_WRAP_DISABLE_BIT))
    else $error("setting moved while idle");
  // Plain and wrapped streams both step the low three bits by one
  a_addr_step: assert property (@(negedge I_SCLK) disable iff (I_CS_N || !I_NRST)
    O_IO_OE != 4'h0 && $past(O_IO_OE) != 4'h0 && O_MEM_ADDR != $past(O_MEM_ADDR)
    |-> O_MEM_ADDR[2:0] == $past(O_MEM_ADDR[2:0]) + 3'h1) else $error("bad address step");
endmodule

bind mior_top mior_top_props u_props (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_SCLK(I_SCLK),
  .I_CS_N(I_CS_N), .O_IO_OE(O_IO_OE), .O_MEM_ADDR(O_MEM_ADDR), .O_SELECTED(O_SELECTED),
  .O_CONT_MODE(O_CONT_MODE), .O_WRAP_DISABLE_BIT(O_WRAP_DISABLE_BIT),
  .O_WRAP_LENGTH_FIELD(O_WRAP_LENGTH_FIELD));

/* mior_host.sv */
/* Host controller model: select, serial clock and lines.
   Assumes the bench hands back the resolved line levels. */
module mior_host (
  // Link out
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io,
  // Resolved lines
  input wire logic [3:0] i_io
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: deselected, clock parked low
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end
  task automatic start();
    #7 o_cs_n = 1'b0;
  endtask
  // One clock: lines set while low, sampled by both sides at the rise
  task automatic beat(input logic [3:0] v, output logic [3:0] s);
    o_io = v;
    #16 s = i_io;
    o_sclk = 1'b1;
    #16 o_sclk = 1'b0;
  endtask
  // Released lines show the inverse, never the old value
  task automatic stop();
    #16 o_cs_n = 1'b1;
    o_io = ~o_io;
  endtask
endmodule

/* mior_top_test.sv */
/* Bench for the read path: row table of reads, then continuous mode,
   refusals and wrapped bursts. Assumes mior_host as link partner. */
module mior_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR = 8'h6e; // Arbitrary value
  localparam logic [7:0] DEV = 8'h29; // Arbitrary value
  typedef struct {logic [7:0] op; logic [23:0] a; logic [7:0] m; int aw, mb, db, dw;} mior_row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic qe = 1'b1;
  logic sclk, cs_n, sel, cont, wdis;
  logic [3:0] hio, o_io, oe, lvl;
  logic [23:0] maddr;
  logic [1:0] wlen;
  int errors = 0;
  int n_compared = 0;
  mior_row_s r;
  // Opcode, address, mode, address lanes, mode clocks, dummy clocks, data lanes
  mior_row_s rows[6] = '{'{8'h6b, 24'h0000fe, 8'h00, 1, 0, 8, 4},
    '{8'hbb, 24'h123457, 8'hcf, 2, 4, 0, 2}, '{8'heb, 24'h00abcd, 8'hdf, 4, 2, 4, 4},
    '{8'he7, 24'h000ff0, 8'h00, 4, 2, 2, 4}, '{8'h90, 24'h000000, 8'h00, 1, 0, 0, 1},
    '{8'h90, 24'h000001, 8'h00, 1, 0, 0, 1}};
  // Wire level: device where enabled, host elsewhere
  assign lvl = (oe & o_io) | (~oe & hio);
  mior_top #(.MFR_ID(MFR), .DEV_ID(DEV)) dut (.I_CLK(clk), .I_NRST(nrst), .I_SCLK(sclk),
    .I_CS_N(cs_n), .I_IO(lvl), .O_IO(o_io), .O_IO_OE(oe), .O_MEM_ADDR(maddr),
    .I_MEM_DATA(maddr[7:0] ^ 8'h5c), .I_QUAD_LINES_ENABLE(qe), .O_SELECTED(sel),
    .O_CONT_MODE(cont), .O_WRAP_DISABLE_BIT(wdis), .O_WRAP_LENGTH_FIELD(wlen));
  mior_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(hio), .i_io(lvl));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [31:0] v, input int n, w);
    logic [3:0] s;
    for (int k = 0; k < n; k++) begin
      host.beat(4'((v >> ((n - 1 - k) * w)) & ((1 << w) - 1)), s);
    end
  endtask
  // Single-line data arrives on line one
  task automatic get(input int w, output logic [7:0] b);
    logic [3:0] s;
    b = 8'h0;
    for (int k = 0; k < 8 / w; k++) begin
      host.beat(~hio, s);
      b = 8'((b << w) | (w == 1 ? {3'h0, s[1]} : s & 4'((1 << w) - 1)));
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  // Opcode 0 means continuous mode; sec is the wrap mask
  task automatic rd(input logic [7:0] op, m, input logic [23:0] a, sec,
      input int aw, mb, db, dw, n, input bit ok);
    logic [7:0] b;
    logic [23:0] ad;
    host.start();
    if (op != 8'h00) put({24'h0, op}, 8, 1);
    put({8'h0, a}, 24 / aw, aw);
    if (mb > 0) put({24'h0, m}, mb, 8 / mb);
    put(32'h0, db, 1);
    for (int k = 0; k < n; k++) begin
      get(dw, b);
      ad = (a & ~sec) | ((a + 24'(k)) & sec);
      if (!ok) chk({4'h0, oe}, 8'h0);
      else if (op == 8'h90) chk(b, (a[0] ^ k[0]) ? DEV : MFR);
      else chk(b, ad[7:0] ^ 8'h5c);
    end
    host.stop();
    #1 chk({4'h0, oe}, 8'h0);
  endtask
  task automatic setw(input logic [2:0] wb);
    host.start();
    put(32'h77, 8, 1);
    put(32'h0, 6, 4);
    put({29'h0, wb}, 1, 4);
    put(32'h0, 1, 4);
    host.stop();
    settle();
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset, row table, then the awkward cases
  initial begin
    repeat (6) @(posedge clk);
    chk({7'h0, wdis}, 8'h1);
    chk({7'h0, cont}, 8'h0);
    chk({7'h0, sel}, 8'h0);
    nrst <= 1'b1;
    settle();
    foreach (rows[i]) begin
      r = rows[i];
      rd(r.op, r.m, r.a, 24'hffffff, r.aw, r.mb, r.db, r.dw, 4, 1'b1);
      $display("row %0d done", i);
    end
    for (int j = 1; j < 4; j++) begin
      r = rows[j];
      rd(r.op, 8'h20, r.a, 24'hffffff, r.aw, r.mb, r.db, r.dw, 2, 1'b1);
      settle();
      chk({7'h0, cont}, 8'h1);
      rd(8'h0, 8'h0, r.a + 24'h20, 24'hffffff, r.aw, r.mb, r.db, r.dw, 2, 1'b1);
      settle();
      chk({7'h0, cont}, 8'h0);
      $display("continuous %0d done", j);
    end
    rd(8'heb, 8'h20, 24'h000400, 24'hffffff, 4, 2, 4, 4, 1, 1'b1);
    host.start();
    put(32'hffffffff, 8, 4);
    host.stop();
    settle();
    chk({7'h0, cont}, 8'h0);
    rd(8'heb, 8'h0, 24'h000400, 24'hffffff, 4, 2, 4, 4, 1, 1'b1);
    @(posedge clk) qe <= 1'b0;
    rd(8'heb, 8'h0, 24'h000500, 24'hffffff, 4, 2, 4, 4, 2, 1'b0);
    rd(8'he7, 8'h0, 24'h000500, 24'hffffff, 4, 2, 2, 4, 2, 1'b0);
    @(posedge clk) qe <= 1'b1;
    $display("refusal done");
    for (int l = 0; l < 4; l++) begin
      setw({l[1:0], 1'b0});
      chk({7'h0, wdis}, 8'h0);
      chk({6'h0, wlen}, {6'h0, l[1:0]});
      rd(l[0] ? 8'he7 : 8'heb, 8'h0, 24'h0301fa, 24'((8 << l) - 1), 4, 2,
        l[0] ? 2 : 4, 4, 70, 1'b1);
    end
    rd(8'h6b, 8'h0, 24'h0301fe, 24'hffffff, 1, 0, 8, 4, 4, 1'b1);
    rd(8'heb, 8'h0, 24'h0301fa, 24'h00003f, 4, 2, 4, 4, 70, 1'b1);
    setw(3'b001);
    chk({7'h0, wdis}, 8'h1);
    rd(8'heb, 8'h0, 24'h0301fa, 24'hffffff, 4, 2, 4, 4, 10, 1'b1);
    $display("wrap done");
    wrap_up();
  end
  // Watchdog: the run needs far less than half a millisecond
  initial begin
    #500000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
